// ### supervisor_pkg.sv
// Purpose: Constants and carrier types for the line mode and fault supervisor
// Assumes: 125 MHz system clock
// Notes: Times are kept in their own unit; cycle counts derive from them
package supervisor_pkg;

	localparam int CLK_MHZ = 125;
	localparam int RISE_QUALIFY_US = 300;
	localparam int FALL_QUALIFY_MS = 54;
	localparam int FAULT_BLANK_US = 30;
	// Least times round up; all are whole here
	localparam int RISE_QUALIFY_CYC = RISE_QUALIFY_US * CLK_MHZ;
	localparam int FALL_QUALIFY_CYC = FALL_QUALIFY_MS * 1000 * CLK_MHZ;
	localparam int FAULT_BLANK_CYC = FAULT_BLANK_US * CLK_MHZ;
	localparam int ONTIME_DIV_HIGH = 3;
	localparam int ONTIME_DIV_LOW = 1;
	localparam int CNT_W = 24;

	// Feed-forward gain codes per line mode
	localparam logic [1:0] GAIN_LOW = 2'h1;
	localparam logic [1:0] GAIN_HIGH = 2'h2;

	// Register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam int IRQ_W = 4;
	localparam int IRQ_HIGH = 0;
	localparam int IRQ_LOW = 1;
	localparam int IRQ_UPPER = 2;
	localparam int IRQ_LOWER = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum {ST_RUN, ST_HICCUP, ST_DISABLED, ST_LATCHED, ST_OT_WAIT} ctl_t;

	typedef struct packed {
		logic line_select;
		logic brownout_stop;
		logic upper_fault;
		logic lower_fault;
		logic otp_exit;
	} comp_t;

	typedef struct packed {
		logic soft_start;
		logic flyback_en;
		logic supply_on;
		logic supply_reset;
		logic brownout;
		logic hiccup_done;
	} stat_t;

	typedef struct packed {
		logic high_line;
		logic [1:0] ff_gain;
		logic [1:0] ontime_div;
		logic ctrl_enable;
		logic hiccup_req;
		logic latched;
		logic otp_pullup;
	} ctl_out_t;

endpackage

// ### line_fault_supervisor.sv
// Purpose: Line mode selection and fault input qualification
// Assumes: Comparator and supply status levels arrive asynchronously
// Notes: Registers over AXI4-Lite; one level interrupt output
// Functional notes
// [R1] Power-up starts in low-line mode
// [R2] Line select held over 300 us enters high
// [R3] Rise timer inhibited until brown-out stop seen
// [R4] 54 ms deasserted timer returns to low
// [R5] High line divides max on-time by three
// [R6] Line mode selects feed-forward gain
// [R7] Qualified upper fault starts triple hiccup
// [R8] Qualified lower fault disables controller
// [R9] Between thresholds no fault, normal operation
// [R10] Option A latches off on overtemperature
// [R11] Option B waits exit threshold and supply-on
// [R12] Both fault comparators blanked 30 us
// [R13] Lower fault ignored during soft-start
// [R14] Option B pull-up held while lower fault
// [R15] Upper detection armed while flyback enabled
// [R16] Latch cleared by brown-out or supply reset
// [R17] Brown-out stop flag drives the inhibit
// [R18] Counter timers, synchronised comparator inputs
`timescale 1ns/1ps
module line_fault_supervisor #(
	parameter int RISE_CYC = supervisor_pkg::RISE_QUALIFY_CYC,
	parameter int FALL_CYC = supervisor_pkg::FALL_QUALIFY_CYC,
	parameter int BLANK_CYC = supervisor_pkg::FAULT_BLANK_CYC,
	parameter bit OPTION_B = 1'b0
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Asynchronous comparator and status inputs
	input wire supervisor_pkg::comp_t COMP,
	input wire supervisor_pkg::stat_t STAT,
	// Supervisor outputs
	output supervisor_pkg::ctl_out_t CTL,
	output logic IRQ,
	// AXI4-Lite slave
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	localparam int W = supervisor_pkg::CNT_W;
	localparam int NS = 11;

	// Two-stage synchronisers for every asynchronous level
	logic [NS-1:0] s1_q, s2_q;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin // see [R18]
		if (!RST_N) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {COMP, STAT};
			s2_q <= s1_q;
		end
	end
	supervisor_pkg::comp_t c;
	supervisor_pkg::stat_t s;
	assign {c, s} = s2_q;

	// Line mode state
	logic high_q, high_d, inhibit_q, inhibit_d;
	logic [W-1:0] rise_q, rise_d, fall_q, fall_d;
	logic ev_high, ev_low;

	always_comb begin
		high_d = high_q;
		inhibit_d = inhibit_q;
		rise_d = '0;
		fall_d = '0;
		ev_high = 1'b0;
		ev_low = 1'b0;
		if (c.brownout_stop)
			inhibit_d = 1'b0; // see [R3] [R17]
		if (!high_q) begin
			if (c.line_select && !inhibit_q) begin // see [R2] [R3]
				if (rise_q == W'(RISE_CYC)) begin
					high_d = 1'b1;
					ev_high = 1'b1;
				end else begin
					rise_d = rise_q + 1'b1;
				end
			end
		end else if (!c.line_select) begin // see [R4]
			if (fall_q == W'(FALL_CYC - 1)) begin
				high_d = 1'b0;
				inhibit_d = !c.brownout_stop;
				ev_low = 1'b1;
			end else begin
				fall_d = fall_q + 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			high_q <= 1'b0; // see [R1]
			inhibit_q <= 1'b0;
			rise_q <= '0;
			fall_q <= '0;
		end else begin
			high_q <= high_d;
			inhibit_q <= inhibit_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end

	// Fault blanking: a fault counts once held longer than the delay
	logic [1:0] raw, qual;
	logic [1:0][W-1:0] bl_q, bl_d;
	assign raw[0] = c.upper_fault && s.flyback_en; // see [R15]
	assign raw[1] = c.lower_fault && !s.soft_start; // see [R13]
	for (genvar i = 0; i < 2; i++) begin : g_blank
		always_comb begin
			bl_d[i] = '0;
			if (raw[i] && bl_q[i] != W'(BLANK_CYC))
				bl_d[i] = bl_q[i] + 1'b1; // see [R12]
			else if (raw[i])
				bl_d[i] = bl_q[i];
		end
		assign qual[i] = raw[i] && bl_q[i] == W'(BLANK_CYC);
		always_ff @(posedge CLK_SYS or negedge RST_N) begin
			if (!RST_N)
				bl_q[i] <= '0;
			else
				bl_q[i] <= bl_d[i];
		end
	end

	// Controller enable state machine
	supervisor_pkg::ctl_t st_q, st_d;
	logic ev_up, ev_lo;
	always_comb begin
		st_d = st_q;
		ev_up = 1'b0;
		ev_lo = 1'b0;
		unique case (st_q)
			supervisor_pkg::ST_RUN: begin // see [R9]
				if (qual[1]) begin
					ev_lo = 1'b1;
					st_d = OPTION_B ? supervisor_pkg::ST_OT_WAIT
						: supervisor_pkg::ST_LATCHED; // see [R8] [R10]
				end else if (qual[0]) begin
					ev_up = 1'b1;
					st_d = supervisor_pkg::ST_HICCUP; // see [R7]
				end
			end
			supervisor_pkg::ST_HICCUP: begin
				if (s.hiccup_done)
					st_d = supervisor_pkg::ST_RUN;
			end
			supervisor_pkg::ST_OT_WAIT: begin
				if (c.otp_exit && s.supply_on)
					st_d = supervisor_pkg::ST_RUN; // see [R11]
			end
			supervisor_pkg::ST_LATCHED: begin
				if (s.brownout || s.supply_reset)
					st_d = supervisor_pkg::ST_RUN; // see [R16]
			end
			supervisor_pkg::ST_DISABLED: begin
				st_d = supervisor_pkg::ST_RUN;
			end
		endcase
	end
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			st_q <= supervisor_pkg::ST_RUN;
		else
			st_q <= st_d;
	end

	// Registered outputs
	supervisor_pkg::ctl_out_t ctl_d;
	logic sw_en_q;
	always_comb begin
		ctl_d.high_line = high_q;
		ctl_d.ff_gain = high_q ? supervisor_pkg::GAIN_HIGH
			: supervisor_pkg::GAIN_LOW; // see [R6]
		ctl_d.ontime_div = high_q ? 2'(supervisor_pkg::ONTIME_DIV_HIGH)
			: 2'(supervisor_pkg::ONTIME_DIV_LOW); // see [R5]
		ctl_d.ctrl_enable = st_q == supervisor_pkg::ST_RUN && sw_en_q;
		ctl_d.hiccup_req = st_q == supervisor_pkg::ST_HICCUP;
		ctl_d.latched = st_q == supervisor_pkg::ST_LATCHED;
		// Pull-up stays on while the lower fault is held, whatever supply
		ctl_d.otp_pullup = !OPTION_B || st_q != supervisor_pkg::ST_OT_WAIT
			|| c.lower_fault || !c.otp_exit; // see [R14]
	end
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			CTL <= '0;
		else
			CTL <= ctl_d;
	end

	// Register file over AXI4-Lite
	logic [supervisor_pkg::IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d, ev;
	logic sw_en_d;
	logic aw_q, aw_d, w_q, w_d, bv_d, rv_d;
	logic [7:0] awa_q, awa_d;
	logic [31:0] wd_q, wd_d, rd_d;
	logic [1:0] br_d, rr_d;
	logic do_wr;
	assign ev = {ev_lo, ev_up, ev_low, ev_high};
	assign AWREADY = !aw_q && !BVALID;
	assign WREADY = !w_q && !BVALID;
	assign ARREADY = !RVALID;
	assign IRQ = |(ist_q & imsk_q);

	always_comb begin
		aw_d = aw_q;
		w_d = w_q;
		awa_d = awa_q;
		wd_d = wd_q;
		if (AWVALID && AWREADY) begin
			aw_d = 1'b1;
			awa_d = AWADDR;
		end
		if (WVALID && WREADY) begin
			w_d = 1'b1;
			wd_d = WDATA & {{8{WSTRB[3]}}, {8{WSTRB[2]}},
				{8{WSTRB[1]}}, {8{WSTRB[0]}}};
		end
		do_wr = aw_q && w_q;
		bv_d = BVALID && !BREADY;
		br_d = BRESP;
		sw_en_d = sw_en_q;
		imsk_d = imsk_q;
		// Set wins over a write-one clear in the same cycle
		ist_d = ist_q;
		if (do_wr) begin
			aw_d = 1'b0;
			w_d = 1'b0;
			bv_d = 1'b1;
			br_d = supervisor_pkg::RESP_OKAY;
			unique case (awa_q)
				supervisor_pkg::ADDR_CTRL: sw_en_d = wd_q[0];
				supervisor_pkg::ADDR_IRQ_STAT:
					ist_d = ist_q & ~wd_q[supervisor_pkg::IRQ_W-1:0];
				supervisor_pkg::ADDR_IRQ_MASK:
					imsk_d = wd_q[supervisor_pkg::IRQ_W-1:0];
				supervisor_pkg::ADDR_STATUS: ;
				default: br_d = supervisor_pkg::RESP_SLVERR;
			endcase
		end
		ist_d = ist_d | ev;
		rv_d = RVALID && !RREADY;
		rd_d = RDATA;
		rr_d = RRESP;
		if (ARVALID && ARREADY) begin
			rv_d = 1'b1;
			rr_d = supervisor_pkg::RESP_OKAY;
			rd_d = '0;
			unique case (ARADDR)
				supervisor_pkg::ADDR_CTRL: rd_d[0] = sw_en_q;
				supervisor_pkg::ADDR_STATUS:
					rd_d[4:0] = {CTL.latched, CTL.hiccup_req,
						CTL.ctrl_enable, inhibit_q, high_q};
				supervisor_pkg::ADDR_IRQ_STAT:
					rd_d[supervisor_pkg::IRQ_W-1:0] = ist_q;
				supervisor_pkg::ADDR_IRQ_MASK:
					rd_d[supervisor_pkg::IRQ_W-1:0] = imsk_q;
				default: rr_d = supervisor_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= '0;
			wd_q <= '0;
			BVALID <= 1'b0;
			BRESP <= supervisor_pkg::RESP_OKAY;
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= supervisor_pkg::RESP_OKAY;
			sw_en_q <= supervisor_pkg::CTRL_RESET[0];
			ist_q <= '0;
			imsk_q <= supervisor_pkg::MASK_RESET[supervisor_pkg::IRQ_W-1:0];
		end else begin
			aw_q <= aw_d;
			w_q <= w_d;
			awa_q <= awa_d;
			wd_q <= wd_d;
			BVALID <= bv_d;
			BRESP <= br_d;
			RVALID <= rv_d;
			RDATA <= rd_d;
			RRESP <= rr_d;
			sw_en_q <= sw_en_d;
			ist_q <= ist_d;
			imsk_q <= imsk_d;
		end
	end

	// Checks
	a_reset_low: assert property (@(posedge CLK_SYS)
		$rose(RST_N) |-> !high_q) // see [R1]
		else $error("line mode not low after reset");
	a_rise_needs_line: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$rose(high_q) |-> $past(c.line_select) && !$past(inhibit_q)) // see [R2]
		else $error("high line entered without qualified select");
	a_inhibit_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		inhibit_q |-> rise_q == '0) // see [R3]
		else $error("rise timer ran while inhibited");
	a_fall_sets_inh: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		$fell(high_q) && !$past(c.brownout_stop) |-> inhibit_q) // see [R4]
		else $error("return to low without inhibit");
	a_ontime_div: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		high_q |=> CTL.ontime_div == 2'(supervisor_pkg::ONTIME_DIV_HIGH)) // see [R5]
		else $error("on-time divider not three in high line");
	a_upper_hiccup: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ev_up |=> st_q == supervisor_pkg::ST_HICCUP ##1 CTL.hiccup_req) // see [R7]
		else $error("upper fault did not hiccup");
	a_blank_armed: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		!s.flyback_en |-> !qual[0]) // see [R15]
		else $error("upper fault qualified while flyback off");
	a_soft_ignore: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s.soft_start |-> !qual[1] && bl_q[1] == '0) // see [R13]
		else $error("lower fault seen during soft-start");
	a_latch_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		st_q == supervisor_pkg::ST_LATCHED && !s.brownout && !s.supply_reset
		|=> st_q == supervisor_pkg::ST_LATCHED) // see [R16]
		else $error("latch released without cause");
	c_high_line: cover property (@(posedge CLK_SYS) $rose(high_q));
	c_back_low: cover property (@(posedge CLK_SYS) $fell(high_q));
	c_hiccup: cover property (@(posedge CLK_SYS) ev_up);
	c_lower: cover property (@(posedge CLK_SYS) ev_lo);
endmodule

// ### comp_model.sv
// Purpose: Behavioural model of the line and fault input comparators
// Assumes: Bench gives line level in volts and fault level in millivolts
// Notes: Ideal comparators, no hysteresis, no delay; outputs asynchronous
`timescale 1ns/1ps
module comp_model #(
	parameter int SEL_V = 240,
	parameter int STOP_V = 101,
	parameter int UP_MV = 3000,
	parameter int LOW_MV = 400,
	parameter int EXIT_MV = 920
) (
	// Sensed levels
	input wire logic [15:0] line_v,
	input wire logic [15:0] fault_mv,
	// Comparator outputs
	output supervisor_pkg::comp_t comp
);
	assign comp.line_select = line_v > SEL_V;
	assign comp.brownout_stop = line_v < STOP_V;
	assign comp.upper_fault = fault_mv > UP_MV;
	assign comp.lower_fault = fault_mv < LOW_MV;
	assign comp.otp_exit = fault_mv > EXIT_MV;
endmodule

// ### tb_line_fault_supervisor.sv
// Purpose: Self-checking bench for the line mode and fault supervisor
// Assumes: Short timer parameters; option A and option B side by side
// Notes: Second instance shares all inputs; only its CTL is judged
`timescale 1ns/1ps
module tb_line_fault_supervisor;
	localparam int RC = 8;
	localparam int FC = 20;
	localparam int BC = 4;
	logic CLK_SYS, RST_N, irq;
	logic [15:0] line_v, fault_mv;
	supervisor_pkg::comp_t cmp;
	supervisor_pkg::stat_t st;
	supervisor_pkg::ctl_out_t ca, cb;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	int fail_count, checked, cycles;

	comp_model comp_model_i (.line_v(line_v), .fault_mv(fault_mv), .comp(cmp));

	line_fault_supervisor #(.RISE_CYC(RC), .FALL_CYC(FC), .BLANK_CYC(BC),
		.OPTION_B(1'b0)) line_fault_supervisor_i (
		.CLK_SYS(CLK_SYS), .RST_N(RST_N), .COMP(cmp), .STAT(st), .CTL(ca),
		.IRQ(irq), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
		.RVALID(rvalid), .RREADY(rready));

	line_fault_supervisor #(.RISE_CYC(RC), .FALL_CYC(FC), .BLANK_CYC(BC),
		.OPTION_B(1'b1)) line_fault_supervisor_b_i (
		.CLK_SYS(CLK_SYS), .RST_N(RST_N), .COMP(cmp), .STAT(st), .CTL(cb),
		.IRQ(), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(),
		.BRESP(), .BVALID(), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(), .RDATA(), .RRESP(),
		.RVALID(), .RREADY(rready));

	initial begin
		CLK_SYS = 1'b0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	task final_report();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge CLK_SYS) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			final_report();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t %s: got %0h want %0h", $time, m, seen, exp);
		end
	endtask

	task run(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask

	task lv(input logic [15:0] v, input int n);
		line_v <= v;
		run(n);
	endtask

	task fv(input logic [15:0] v, input int n);
		fault_mv <= v;
		run(n);
	endtask

	task axw(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge CLK_SYS);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge CLK_SYS); while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge CLK_SYS); while (!arready);
		arvalid <= 1'b0;
		do @(posedge CLK_SYS); while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task t_reset();
		check(ca.high_line, 0, "power-up mode");
		check(ca.ff_gain, supervisor_pkg::GAIN_LOW, "low gain");
		check(ca.ontime_div, supervisor_pkg::ONTIME_DIV_LOW, "low div");
		check(ca.ctrl_enable, 1, "enabled between thresholds");
		axr(supervisor_pkg::ADDR_IRQ_MASK);
		check(rd, supervisor_pkg::MASK_RESET, "mask reset");
		axr(supervisor_pkg::ADDR_CTRL);
		check(rd, supervisor_pkg::CTRL_RESET, "control reset");
		axr(8'h40);
		check(rs, supervisor_pkg::RESP_SLVERR, "unmapped read response");
		check(rd, 32'h0000_0000, "unmapped read data");
	endtask

	task t_rise();
		axw(supervisor_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
		check(rs, supervisor_pkg::RESP_OKAY, "mask write");
		lv(300, RC - 2);
		lv(120, 12);
		check(ca.high_line, 0, "short line pulse");
		lv(300, RC + 8);
		check(ca.high_line, 1, "high line entered");
		check(ca.ff_gain, supervisor_pkg::GAIN_HIGH, "high gain");
		check(ca.ontime_div, supervisor_pkg::ONTIME_DIV_HIGH, "div 3");
		check(irq, 1, "entry interrupt");
		axr(supervisor_pkg::ADDR_IRQ_STAT);
		check(rd[supervisor_pkg::IRQ_HIGH], 1, "entry status bit");
		axw(supervisor_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
		run(2);
		check(irq, 0, "interrupt cleared");
	endtask

	task t_fall();
		lv(120, FC - 4);
		check(ca.high_line, 1, "fall timer early");
		lv(300, 4);
		lv(120, FC - 4);
		check(ca.high_line, 1, "fall timer restarted");
		run(12);
		check(ca.high_line, 0, "back to low");
		check(ca.ff_gain, supervisor_pkg::GAIN_LOW, "low gain again");
		lv(300, RC + 8);
		check(ca.high_line, 0, "rise inhibited");
		axr(supervisor_pkg::ADDR_STATUS);
		check(rd[1], 1, "inhibit flag");
		lv(90, 6);
		lv(300, RC + 8);
		check(ca.high_line, 1, "rise after stop");
		lv(120, FC + 8);
	endtask

	task t_upper();
		fv(3500, BC - 2);
		fv(1000, 10);
		check(ca.hiccup_req, 0, "short upper pulse");
		fv(3500, BC + 8);
		check(ca.hiccup_req, 1, "hiccup entered");
		fv(1000, 2);
		st.hiccup_done <= 1'b1;
		run(4);
		st.hiccup_done <= 1'b0;
		run(4);
		check(ca.hiccup_req, 0, "hiccup finished");
		st.flyback_en <= 1'b0;
		fv(3500, BC + 8);
		check(ca.hiccup_req, 0, "upper disarmed");
		fv(1000, 4);
		st.flyback_en <= 1'b1;
	endtask

	task t_lower();
		st.soft_start <= 1'b1;
		fv(200, BC + 8);
		check(ca.ctrl_enable, 1, "lower ignored");
		fv(1000, 4);
		st.soft_start <= 1'b0;
		fv(200, BC + 8);
		check(ca.latched, 1, "option A latched");
		check(ca.ctrl_enable, 0, "A disabled");
		check(cb.ctrl_enable, 0, "B disabled");
		st.supply_on <= 1'b0;
		run(4);
		check(cb.otp_pullup, 1, "pull-up kept");
		fv(600, 10);
		check(cb.ctrl_enable, 0, "below exit");
		fv(1000, 10);
		check(cb.ctrl_enable, 0, "supply not on");
		check(cb.otp_pullup, 0, "pull-up off once fault gone");
		st.supply_on <= 1'b1;
		run(6);
		check(cb.ctrl_enable, 1, "B re-enabled");
		check(ca.latched, 1, "latch holds");
		st.brownout <= 1'b1;
		run(4);
		st.brownout <= 1'b0;
		run(4);
		check(ca.latched, 0, "latch cleared");
	endtask

	initial begin
		RST_N = 1'b0;
		line_v = 16'h0078;
		fault_mv = 16'h03E8;
		st = '0;
		st.supply_on = 1'b1;
		st.flyback_en = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		fail_count = 0;
		checked = 0;
		cycles = 0;
		run(6);
		RST_N <= 1'b1;
		run(4);
		t_reset();
		t_rise();
		t_fall();
		t_upper();
		t_lower();
		final_report();
	end
endmodule
